// File: design/ttp_pkg.sv
// package of constants and types for the triple timer pin control block
package ttp_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] TTP_OFF_CTRL_STAT0 = 8'h00;
  localparam logic [7:0] TTP_OFF_CTRL_STAT1 = 8'h10;
  localparam logic [7:0] TTP_OFF_CTRL_STAT2 = 8'h20;
  localparam logic [7:0] TTP_OFF_COMPARE0 = 8'h04;
  localparam logic [7:0] TTP_OFF_COMPARE1 = 8'h14;
  localparam logic [7:0] TTP_OFF_COMPARE2 = 8'h24;
  localparam logic [7:0] TTP_OFF_COUNT0 = 8'h08;
  localparam logic [7:0] TTP_OFF_COUNT1 = 8'h18;
  localparam logic [7:0] TTP_OFF_COUNT2 = 8'h28;
  localparam logic [7:0] TTP_OFF_CAPTURE0 = 8'h0c;
  localparam logic [7:0] TTP_OFF_IRQ_STAT = 8'h30;
  localparam logic [7:0] TTP_OFF_IRQ_MASK = 8'h34;
  localparam logic [7:0] TTP_OFF_POWER = 8'h38;
  // ---------------------------------------------------------------
  // control/status field positions
  // ---------------------------------------------------------------
  localparam int TTP_BIT_ENABLE = 0;
  localparam int TTP_BIT_MODE_LO = 1;
  localparam int TTP_BIT_MODE_HI = 3;
  localparam int TTP_BIT_CLK_EXT = 4;
  localparam int TTP_BIT_IRQ_EN = 5;
  localparam int TTP_BIT_GPIO_DIR = 6;
  localparam int TTP_BIT_GPIO_OUT = 7;
  localparam int TTP_BIT_PIN_IN = 8;
  localparam int TTP_BIT_MATCH = 9;
  localparam int TTP_BIT_POWER_STOP = 0;
  localparam int TTP_BIT_POWER_WAIT = 1;
  // ---------------------------------------------------------------
  // reset values and sizes
  // ---------------------------------------------------------------
  localparam int TTP_NUM_CH = 3;
  localparam int TTP_CNT_W = 24;
  localparam logic [7:0] TTP_CTRL_RESET = 8'h00;
  localparam logic [23:0] TTP_CMP_RESET = 24'hff_ffff;
  localparam logic [31:0] TTP_READ_UNMAPPED = 32'h0000_0000;
  // ---------------------------------------------------------------
  // channel modes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    TTP_MODE_GPIO = 3'h0,
    TTP_MODE_TIMER = 3'h1,
    TTP_MODE_PULSE = 3'h2,
    TTP_MODE_WATCHDOG = 3'h3,
    TTP_MODE_EVENT = 3'h4,
    TTP_MODE_MEASURE = 3'h5
  } ttp_mode_t;
endpackage

// File: design/ttp_chan_if.sv
// interface between the register front end and one timer channel
`timescale 1ns/100ps
interface ttp_chan_if;
  import ttp_pkg::*;
  logic [7:0] ctrl;
  logic [23:0] compare;
  logic count_clear;
  logic stopped;
  logic pin_sync;
  logic [23:0] count;
  logic [23:0] capture;
  logic match_pulse;
  logic pin_out;
  logic pin_oe_n;
  modport ctl (output ctrl, output compare, output count_clear, output stopped,
    output pin_sync, input count, input capture, input match_pulse, input pin_out,
    input pin_oe_n);
  modport chan (input ctrl, input compare, input count_clear, input stopped,
    input pin_sync, output count, output capture, output match_pulse, output pin_out,
    output pin_oe_n);
endinterface

// File: design/ttp_sync.sv
// two-flop synchroniser for one pin input
`timescale 1ns/100ps
module ttp_sync (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic async_in,
  output logic sync_out
);
  typedef struct packed {
    logic meta;
    logic sync;
  } ttp_sync_t;
  ttp_sync_t st;
  ttp_sync_t next_st;
  // first flop feeds only the second
  always_comb begin
    next_st.meta = async_in;
    next_st.sync = st.meta;
    if (!resetn) begin
      next_st = '0;
    end
  end
  always_ff @(posedge mclk) begin
    st <= next_st;
  end
  assign sync_out = st.sync;
endmodule

// File: design/ttp_channel.sv
// one timer channel: counter, compare, pin direction
`timescale 1ns/100ps
module ttp_channel
  import ttp_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  ttp_chan_if.chan ch
);
  typedef struct packed {
    logic pin_prev;
    logic [23:0] count;
    logic [23:0] capture;
    logic match;
    logic wave;
  } ttp_chan_t;
  ttp_chan_t st;
  ttp_chan_t next_st;
  logic enable;
  logic ext_clk;
  logic [2:0] mode;
  logic pin_rise;
  logic tick;
  logic drives;
  assign enable = ch.ctrl[TTP_BIT_ENABLE];
  assign ext_clk = ch.ctrl[TTP_BIT_CLK_EXT];
  assign mode = ch.ctrl[TTP_BIT_MODE_HI:TTP_BIT_MODE_LO];
  // pin ignored while stopped
  assign pin_rise = ch.pin_sync && !st.pin_prev && !ch.stopped; // R07
  // internal clock or pin events
  assign tick = enable && !ch.stopped && (ext_clk ? pin_rise : 1'b1); // R02
  // direction by mode; gpio follows its own direction bit
  always_comb begin
    case (mode)
      TTP_MODE_TIMER, TTP_MODE_PULSE, TTP_MODE_WATCHDOG: drives = 1'b1; // R05
      TTP_MODE_EVENT, TTP_MODE_MEASURE: drives = 1'b0; // R04
      TTP_MODE_GPIO: drives = ch.ctrl[TTP_BIT_GPIO_DIR]; // R06
      default: drives = 1'b0;
    endcase
  end
  // count, compare and capture
  always_comb begin
    next_st = st;
    next_st.match = 1'b0;
    next_st.pin_prev = ch.pin_sync;
    if (ch.count_clear || !enable) begin
      next_st.count = '0;
      next_st.wave = 1'b0;
    end else if (mode == TTP_MODE_MEASURE) begin
      // pin edge latches elapsed internal clocks
      if (pin_rise) begin
        next_st.capture = st.count;
        next_st.count = '0;
        next_st.match = 1'b1;
      end else if (!ch.stopped) begin
        next_st.count = st.count + 24'h00_0001;
      end
    end else if (tick) begin
      if (st.count + 24'h00_0001 >= ch.compare) begin
        next_st.count = '0;
        next_st.match = 1'b1; // R03
        // pulse mode toggles, timer/watchdog flag on pin
        next_st.wave = (mode == TTP_MODE_PULSE) ? !st.wave : 1'b1; // R03
      end else begin
        next_st.count = st.count + 24'h00_0001;
        if (mode != TTP_MODE_PULSE) begin
          next_st.wave = 1'b0;
        end
      end
    end
    if (!resetn) begin
      next_st = '0;
    end
  end
  always_ff @(posedge mclk) begin
    st <= next_st;
  end
  assign ch.count = st.count;
  assign ch.capture = st.capture;
  assign ch.match_pulse = st.match;
  assign ch.pin_out = (mode == TTP_MODE_GPIO) ? ch.ctrl[TTP_BIT_GPIO_OUT] : st.wave;
  // stop tri-states a driving pin; wait changes nothing
  assign ch.pin_oe_n = ch.stopped ? 1'b1 : !drives; // R08 R09
endmodule

// File: design/ttp_top.sv
// top of the triple timer: avalon slave, irq, three channels
//
// The register addresses and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/100ps
// Summary of operation
// R01: three identical independent channels, each with its own pin and control/status word.
// R02: each channel counts either mclk or rising edges on its own pin.
// R03: on reaching the compare value a channel flags an interrupt or drives its pin.
// R04: event counter and measurement modes use the pin as an input.
// R05: watchdog, timer and pulse modes drive the pin as an output.
// R06: after reset the pin is a gpio input; the control word can make it output or timer pin.
// R07: in stop an input pin stays input and its value is ignored.
// R08: in stop a pin that was driving is released to high impedance.
// R09: wait leaves every pin direction and drive level unchanged.
// R10: a match sets the channel status flag, which interrupts only if enabled.
module ttp_top
  import ttp_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  input wire logic timer_pin_0_in,
  output logic timer_pin_0_out,
  output logic timer_pin_0_oe_n,
  input wire logic timer_pin_1_in,
  output logic timer_pin_1_out,
  output logic timer_pin_1_oe_n,
  input wire logic timer_pin_2_in,
  output logic timer_pin_2_out,
  output logic timer_pin_2_oe_n
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0][7:0] ctrl;
    logic [2:0][23:0] compare;
    logic [2:0] count_clear;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic stop;
    logic wait_st;
    logic answered;
    logic [31:0] rdata;
    logic irq;
  } ttp_top_t;
  ttp_top_t st;
  ttp_top_t next_st;
  ttp_chan_if chi [TTP_NUM_CH] ();
  logic [2:0] pin_raw;
  logic [2:0] pin_sync;
  logic [2:0] match;
  logic [2:0] pin_out;
  logic [2:0] pin_oe_n;
  logic [2:0][23:0] count;
  logic [2:0][23:0] capture;
  logic [2:0][31:0] ch_stat;
  logic access;
  logic [1:0] sel;
  logic [7:0] offs;
  logic [31:0] wmask;
  logic [31:0] rmux;
  assign pin_raw = {timer_pin_2_in, timer_pin_1_in, timer_pin_0_in};
  // ---------------------------------------------------------------
  // three independent channels
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < TTP_NUM_CH; gi++) begin : g_ch
      ttp_sync u_sync (
        .mclk(mclk),
        .resetn(resetn),
        .async_in(pin_raw[gi]),
        .sync_out(pin_sync[gi])
      );
      // each channel has private config; only the stop bit is shared
      assign chi[gi].ctrl = st.ctrl[gi]; // R01
      assign chi[gi].compare = st.compare[gi];
      assign chi[gi].count_clear = st.count_clear[gi];
      assign chi[gi].stopped = st.stop;
      assign chi[gi].pin_sync = pin_sync[gi];
      assign match[gi] = chi[gi].match_pulse;
      assign pin_out[gi] = chi[gi].pin_out;
      assign pin_oe_n[gi] = chi[gi].pin_oe_n;
      assign count[gi] = chi[gi].count;
      assign capture[gi] = chi[gi].capture;
      assign ch_stat[gi] = {22'h00_0000, st.irq_stat[gi], pin_sync[gi], st.ctrl[gi]};
      ttp_channel u_chan (
        .mclk(mclk),
        .resetn(resetn),
        .ch(chi[gi])
      );
    end
  endgenerate
  assign timer_pin_0_out = pin_out[0];
  assign timer_pin_1_out = pin_out[1];
  assign timer_pin_2_out = pin_out[2];
  assign timer_pin_0_oe_n = pin_oe_n[0];
  assign timer_pin_1_oe_n = pin_oe_n[1];
  assign timer_pin_2_oe_n = pin_oe_n[2];
  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  // one wait cycle per access keeps read data registered
  assign access = (avs_read || avs_write) && !st.answered;
  assign offs = avs_address & 8'hcf;
  assign sel = avs_address[5:4];
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  // read mux, unmapped and channel index 3 read zero
  always_comb begin
    rmux = TTP_READ_UNMAPPED;
    if (avs_address == TTP_OFF_IRQ_STAT) begin
      rmux = {29'h0000_0000, st.irq_stat};
    end else if (avs_address == TTP_OFF_IRQ_MASK) begin
      rmux = {29'h0000_0000, st.irq_mask};
    end else if (avs_address == TTP_OFF_POWER) begin
      rmux = {30'h0000_0000, st.wait_st, st.stop};
    end else if (sel != 2'h3) begin
      case (offs)
        TTP_OFF_CTRL_STAT0: rmux = ch_stat[sel];
        TTP_OFF_COMPARE0: rmux = {8'h00, st.compare[sel]};
        TTP_OFF_COUNT0: rmux = {8'h00, count[sel]};
        TTP_OFF_CAPTURE0: rmux = {8'h00, capture[sel]};
        default: rmux = TTP_READ_UNMAPPED;
      endcase
    end
  end
  // ---------------------------------------------------------------
  // register writes, status flags and interrupt
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.count_clear = '0;
    next_st.answered = access;
    if (access && avs_read) begin
      next_st.rdata = rmux;
    end
    if (access && avs_write) begin
      if (avs_address == TTP_OFF_IRQ_MASK) begin
        next_st.irq_mask = (st.irq_mask & ~wmask[2:0]) | (avs_writedata[2:0] & wmask[2:0]);
      end else if (avs_address == TTP_OFF_IRQ_STAT) begin
        next_st.irq_stat = st.irq_stat & ~(avs_writedata[2:0] & wmask[2:0]);
      end else if (avs_address == TTP_OFF_POWER) begin
        if (avs_byteenable[0]) begin
          next_st.stop = avs_writedata[TTP_BIT_POWER_STOP];
          // wait only records state, pins untouched
          next_st.wait_st = avs_writedata[TTP_BIT_POWER_WAIT]; // R09
        end
      end else if (sel != 2'h3) begin
        case (offs)
          TTP_OFF_CTRL_STAT0: begin
            // control word picks gpio dir or timer function
            if (avs_byteenable[0]) begin
              next_st.ctrl[sel] = avs_writedata[7:0]; // R06
            end
            // writing one to the match bit clears it
            if (avs_byteenable[1] && avs_writedata[TTP_BIT_MATCH]) begin
              next_st.irq_stat[sel] = 1'b0;
            end
          end
          TTP_OFF_COMPARE0: begin
            // unselected lanes keep their old bytes
            next_st.compare[sel] = (st.compare[sel] & ~wmask[23:0]) |
              (avs_writedata[23:0] & wmask[23:0]);
          end
          TTP_OFF_COUNT0: next_st.count_clear[sel] = 1'b1;
          default: next_st.count_clear = '0;
        endcase
      end
    end
    // set beats clear in the same cycle
    next_st.irq_stat = next_st.irq_stat | match; // R10
    next_st.irq = |(next_st.irq_stat & st.irq_mask & {st.ctrl[2][TTP_BIT_IRQ_EN],
      st.ctrl[1][TTP_BIT_IRQ_EN], st.ctrl[0][TTP_BIT_IRQ_EN]}); // R10 R03
    if (!resetn) begin
      next_st = '0;
      next_st.compare = {TTP_NUM_CH{TTP_CMP_RESET}};
      next_st.ctrl = {TTP_NUM_CH{TTP_CTRL_RESET}}; // R06
    end
  end
  always_ff @(posedge mclk) begin
    st <= next_st;
  end
  assign avs_waitrequest = (avs_read || avs_write) && !st.answered;
  assign avs_readdata = st.rdata;
  assign irq = st.irq;
endmodule

// File: verif/ttp_top_assertions.sv
// concurrent checks on the ports of the triple timer top
`timescale 1ns/100ps
module ttp_top_assertions
  import ttp_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic irq,
  input wire logic timer_pin_0_in,
  input wire logic timer_pin_0_out,
  input wire logic timer_pin_0_oe_n,
  input wire logic timer_pin_1_in,
  input wire logic timer_pin_1_out,
  input wire logic timer_pin_1_oe_n,
  input wire logic timer_pin_2_in,
  input wire logic timer_pin_2_out,
  input wire logic timer_pin_2_oe_n
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic stop_on;
  logic [2:0] mask_q;
  logic wr_done;
  logic wr_take;
  logic [2:0] oe_all;
  // ---------------------------------------------------------------
  // shadow of stop and mask; mask updated when a write completes, stop when it is taken
  // ---------------------------------------------------------------
  assign wr_done = avs_write && !avs_waitrequest && avs_byteenable[0];
  // stop acts at the taking edge, so its shadow must not lag the pins
  assign wr_take = avs_write && avs_waitrequest && avs_byteenable[0];
  assign oe_all = {timer_pin_2_oe_n, timer_pin_1_oe_n, timer_pin_0_oe_n};
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      stop_on <= 1'b0;
      mask_q <= 3'h0;
    end else begin
      if (wr_take && avs_address == TTP_OFF_POWER) stop_on <= avs_writedata[TTP_BIT_POWER_STOP];
      if (wr_done && avs_address == TTP_OFF_IRQ_MASK) mask_q <= avs_writedata[2:0];
    end
  end
  property p_access;
    $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_access: assert property (p_access) else $error("access not answered after one wait");
  property p_reset;
    @(posedge mclk) disable iff (1'b0) !resetn |=> !irq && (oe_all == 3'h7);
  endproperty
  a_reset: assert property (p_reset) else $error("pins or irq wrong in reset");
  property p_stop;
    stop_on |-> oe_all == 3'h7;
  endproperty
  a_stop: assert property (p_stop) else $error("pin driven while stopped");
  property p_wait_pins;
    $rose(avs_write) && avs_address == TTP_OFF_POWER && avs_writedata[1:0] == 2'b10
      && !stop_on |=> $stable(oe_all) [*2];
  endproperty
  a_wait_pins: assert property (p_wait_pins) else $error("wait moved a pin");
  property p_gpio_out;
    wr_done && avs_address == TTP_OFF_CTRL_STAT0 && avs_writedata[3:1] == 3'h0
      && avs_writedata[6] && !stop_on
      |=> !timer_pin_0_oe_n && timer_pin_0_out == $past(avs_writedata[7]);
  endproperty
  a_gpio_out: assert property (p_gpio_out) else $error("gpio output not driven");
  property p_timer_out;
    wr_done && avs_address == TTP_OFF_CTRL_STAT2 && avs_writedata[3:0] == 4'h3
      && !stop_on |=> !timer_pin_2_oe_n;
  endproperty
  a_timer_out: assert property (p_timer_out) else $error("timer pin not output");
  property p_unmapped;
    avs_read && !avs_waitrequest && avs_address == 8'h3c |-> avs_readdata == TTP_READ_UNMAPPED;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_irq_mask;
    mask_q == 3'h0 |-> !irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq while fully masked");
  c_irq: cover property (irq);
  c_stop: cover property (stop_on && $rose(timer_pin_0_oe_n));
  c_pulse: cover property (!timer_pin_2_oe_n && $rose(timer_pin_2_out));
endmodule

// File: verif/ttp_pin_partner.sv
// event source and pin load standing on one timer pin
`timescale 1ns/100ps
module ttp_pin_partner (
  input wire logic mclk,
  input wire logic pin_out,
  input wire logic pin_oe_n,
  output logic pin_in,
  output int rise_count
);
  logic drive_lvl = 1'b0;
  logic last_wire = 1'b0;
  initial rise_count = 0;
  // wire level: the device wins while it drives, else the source level
  assign pin_in = pin_oe_n ? drive_lvl : pin_out;
  // load side counts rising edges that the device drives
  always @(posedge mclk) begin
    if (!pin_oe_n && pin_out && !last_wire) rise_count <= rise_count + 1;
    last_wire <= pin_in;
  end
  // source side: each level held 4 cycles, longer than sync plus edge detect
  task automatic pulses(input int n);
    repeat (n) begin
      repeat (4) @(posedge mclk);
      drive_lvl <= 1'b1;
      repeat (4) @(posedge mclk);
      drive_lvl <= 1'b0;
    end
  endtask
endmodule

// File: verif/triple_timer_pin_control_tb_top.sv
// self-checking bench for the triple timer top
`timescale 1ns/100ps
module triple_timer_pin_control_tb_top;
  import ttp_pkg::*;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  wire logic [2:0] p_in;
  logic [2:0] p_out;
  logic [2:0] p_oe_n;
  int rises [3];
  int miscompares = 0;
  int check_count = 0;
  logic [31:0] rd;
  logic [31:0] keep;
  initial forever #5 mclk = ~mclk;
  ttp_top u_ttp_top (.mclk(mclk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq),
    .timer_pin_0_in(p_in[0]), .timer_pin_0_out(p_out[0]), .timer_pin_0_oe_n(p_oe_n[0]),
    .timer_pin_1_in(p_in[1]), .timer_pin_1_out(p_out[1]), .timer_pin_1_oe_n(p_oe_n[1]),
    .timer_pin_2_in(p_in[2]), .timer_pin_2_out(p_out[2]), .timer_pin_2_oe_n(p_oe_n[2]));
  // one partner per pin, so channels are exercised side by side
  for (genvar g = 0; g < 3; g++) begin : g_pin
    ttp_pin_partner u_pin (.mclk(mclk), .pin_out(p_out[g]), .pin_oe_n(p_oe_n[g]),
      .pin_in(p_in[g]), .rise_count(rises[g]));
  end
  // ---------------------------------------------------------------
  // compare, bus and closing tasks
  // ---------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: bit %b expected %b", $time, got, exp);
    end
  endtask
  // request held until waitrequest is sampled low at a rising edge, then released
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 50) begin
      miscompares++;
      final_report();
    end
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      bus(1'b0, 8'(16 * i), 32'h0000_0000);
      chk_word(rd & 32'h0000_00ff, 32'h0000_0000);
      chk_bit(p_oe_n[i], 1'b1);
    end
    bus(1'b0, TTP_OFF_COMPARE0, 32'h0000_0000);
    chk_word(rd & 32'h00ff_ffff, {8'h00, TTP_CMP_RESET});
    bus(1'b1, 8'h3c, 32'hffff_ffff);
    bus(1'b0, 8'h3c, 32'h0000_0000);
    chk_word(rd, TTP_READ_UNMAPPED);
    // gpio output on pin 0, then an event counter on pin 1
    bus(1'b1, TTP_OFF_CTRL_STAT0, 32'h0000_00c0);
    chk_bit(p_oe_n[0], 1'b0);
    chk_bit(p_out[0], 1'b1);
    bus(1'b1, TTP_OFF_COMPARE1, 32'h0000_0064);
    bus(1'b1, TTP_OFF_CTRL_STAT1, 32'h0000_0019);
    g_pin[1].u_pin.pulses(3);
    bus(1'b0, TTP_OFF_COUNT1, 32'h0000_0000);
    chk_word(rd, 32'h0000_0003);
    chk_bit(p_oe_n[1], 1'b1);
    // timer on pin 2 with its interrupt masked first
    bus(1'b1, TTP_OFF_IRQ_MASK, 32'h0000_0000);
    bus(1'b1, TTP_OFF_COMPARE2, 32'h0000_0005);
    bus(1'b1, TTP_OFF_CTRL_STAT2, 32'h0000_0023);
    rd = 32'h0000_0000;
    for (int i = 0; i < 20 && rd[2] !== 1'b1; i++) bus(1'b0, TTP_OFF_IRQ_STAT, 32'h0000_0000);
    chk_word(rd & 32'h0000_0004, 32'h0000_0004);
    chk_bit(irq, 1'b0);
    chk_bit(p_oe_n[2], 1'b0);
    chk_bit(rises[2] > 0, 1'b1);
    bus(1'b1, TTP_OFF_IRQ_MASK, 32'h0000_0004);
    bus(1'b0, TTP_OFF_CTRL_STAT0, 32'h0000_0000);
    chk_bit(irq, 1'b1);
    bus(1'b1, TTP_OFF_CTRL_STAT2, 32'h0000_0022);
    bus(1'b1, TTP_OFF_IRQ_STAT, 32'h0000_0004);
    bus(1'b0, TTP_OFF_IRQ_STAT, 32'h0000_0000);
    chk_word(rd & 32'h0000_0007, 32'h0000_0000);
    chk_bit(irq, 1'b0);
    // stop releases outputs and ignores pin events
    bus(1'b1, TTP_OFF_POWER, 32'h0000_0001);
    for (int i = 0; i < 3; i++) chk_bit(p_oe_n[i], 1'b1);
    bus(1'b0, TTP_OFF_COUNT1, 32'h0000_0000);
    keep = rd;
    g_pin[1].u_pin.pulses(2);
    bus(1'b0, TTP_OFF_COUNT1, 32'h0000_0000);
    chk_word(rd, keep);
    bus(1'b1, TTP_OFF_POWER, 32'h0000_0000);
    chk_bit(p_oe_n[0], 1'b0);
    // wait leaves pins and counting alone
    bus(1'b1, TTP_OFF_POWER, 32'h0000_0002);
    chk_bit(p_oe_n[0], 1'b0);
    chk_bit(p_out[0], 1'b1);
    g_pin[1].u_pin.pulses(1);
    bus(1'b0, TTP_OFF_COUNT1, 32'h0000_0000);
    chk_word(rd, keep + 32'h0000_0001);
    // measure on pin 1: rises 8 cycles apart, count restarts at each rise
    bus(1'b1, TTP_OFF_CTRL_STAT1, 32'h0000_000b);
    g_pin[1].u_pin.pulses(2);
    bus(1'b0, TTP_OFF_COUNT1 + 8'h04, 32'h0000_0000);
    chk_word(rd, 32'h0000_0007);
    chk_bit(p_oe_n[1], 1'b1);
    // pulse mode on pin 2 toggles at every match, so the load sees new rises
    keep = rises[2];
    bus(1'b1, TTP_OFF_CTRL_STAT2, 32'h0000_0005);
    repeat (30) @(posedge mclk);
    chk_bit(rises[2] > keep, 1'b1);
    chk_bit(p_oe_n[2], 1'b0);
    final_report();
  end
endmodule
bind ttp_top ttp_top_assertions u_ttp_top_assertions (.mclk(mclk), .resetn(resetn),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
  .timer_pin_0_in(timer_pin_0_in), .timer_pin_0_out(timer_pin_0_out),
  .timer_pin_0_oe_n(timer_pin_0_oe_n), .timer_pin_1_in(timer_pin_1_in),
  .timer_pin_1_out(timer_pin_1_out), .timer_pin_1_oe_n(timer_pin_1_oe_n),
  .timer_pin_2_in(timer_pin_2_in), .timer_pin_2_out(timer_pin_2_out),
  .timer_pin_2_oe_n(timer_pin_2_oe_n));
